// >>> rtl/pdw_pkg.sv
// Purpose: Shared constants and types for the power-down and wakeup sequencer
// Assumes: 32-bit APB data, one register per aligned word
// Notes:   All offsets are byte addresses
package pdw_pkg;
  localparam logic [11:0] OFF_CMD      = 12'h000;
  localparam logic [11:0] OFF_STATUS   = 12'h004;
  localparam logic [11:0] OFF_WAKE_EN  = 12'h008;
  localparam logic [11:0] OFF_WAKE_CND = 12'h00C;
  localparam logic [11:0] OFF_PIN_WAKE = 12'h010;
  localparam logic [11:0] OFF_PULLUP0  = 12'h014;
  localparam logic [11:0] OFF_PULLUP1  = 12'h018;
  localparam logic [11:0] OFF_EXT_IRQ  = 12'h01C;
  localparam logic [11:0] OFF_CORE     = 12'h020;

  // Command codes written to OFF_CMD
  localparam logic [3:0] CMD_MONITOR_KEEP = 4'h1;
  localparam logic [3:0] CMD_ARM          = 4'h2;
  localparam logic [3:0] CMD_CLOCK_HOLD   = 4'h3;
  localparam logic [3:0] CMD_RAM_HOLD     = 4'h4;
  localparam logic [3:0] CMD_WDT_RESTART  = 4'h5;
  localparam logic [3:0] CMD_CLR_T3F      = 4'h6;
  localparam logic [3:0] CMD_OTHER        = 4'h0;

  // Status bit positions
  localparam int ST_WARM    = 0;
  localparam int ST_T3F     = 1;
  localparam int ST_KEEP    = 2;
  localparam int ST_ARMED   = 3;
  localparam int ST_CLKHOLD = 4;
  localparam int ST_RAMHOLD = 5;

  localparam logic [3:0] REG4_RESET   = 4'h0;
  localparam logic [2:0] SP_RAM_HOLD  = 3'h7;
  localparam logic [1:0] COUNTER_IO_PIN_IN_MODE = 2'h3;
  localparam int         PWK_ENABLE   = 0;
  localparam int         PWK_EDGE     = 1;
  localparam int         EXI_LEVEL    = 2;
  localparam int         EXI_INPUT_EN = 3;

  typedef enum logic [1:0] {PDW_RUN, PDW_CLOCK_HOLD, PDW_RAM_HOLD} pdw_state_t;

  // Retained control registers
  typedef struct packed {
    logic [3:0] wake_en;
    logic [3:0] wake_cond;
    logic [3:0] pin_wake;
    logic [3:0] pullup0;
    logic [3:0] pullup1;
    logic [3:0] ext_irq;
  } pdw_ctrl_t;

  // Core initialisation strobes
  typedef struct packed {
    logic init_core;
    logic init_sp;
    logic timers12_undef;
    logic display_off;
    logic osc_stop;
  } pdw_init_t;
endpackage : pdw_pkg

// >>> rtl/pdw_sequencer.sv
// Purpose: Power-down entry, wakeup and warm/cold start sequencer with APB registers
// Assumes: Wakeup pins, timer 3 underflow and drop detect are async to pclk
// Notes:   Zero-wait APB slave; unmapped addresses read zero and answer pslverr
// Operation
// - Supply-drop detection forces a microcontroller reset.
// - Monitor-keep op sets latch keeping drop monitor alive in sleep.
// - Monitor-keep latch acts once; only system reset clears it.
// - Arm then clock-hold op enters clock-hold; arm then RAM-hold enters RAM-hold.
// - Without prior arm, hold ops are no-ops.
// - Clock-hold keeps RAM, reset, sub oscillator, display and timer 3.
// - RAM-hold stops oscillation; only external wakeup returns.
// - Clock-hold returns on external wakeup or timer 3 underflow flag.
// - Warm start fetches from page 0 address 0, warm flag set.
// - Cold start fetches from page 0 address 0, warm flag cleared.
// - Warm flag and timer 3 flag are readable by software.
// - Entering power-down initialises core state; control registers retained.
// - RAM-hold entry sets stack pointer to 7.
// - Timers 1, 2 undefined in sleep; RAM-hold turns display off.
// - RAM-hold drives counter pin low unless input mode 11 selected.
// - Wakeup enable register selects port 0 and 1 key-on pairs.
// - Wakeup condition register selects port 1 edge/level and polarity.
// - Pin wakeup register enables interrupt-pin wakeup, edge or level.
// - Two pull-up registers switch port 0 and port 1 pull-ups.
// - External irq control sets edge, pin enable and wakeup level.
// - Falling edge on enabled port 0 key-on pin wakes device.
// - Timer 3 flag already set at clock-hold entry returns at once.
//
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/1ps
module pdw_sequencer (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic [3:0]         port0_in,
  input  wire logic [3:0]         port1_in,
  input  wire logic               int_pin_in,
  input  wire logic               timer3_underflow,
  input  wire logic               drop_detect,
  input  wire logic               wdt_reset,
  input  wire logic [1:0]         counter_pin_mode,
  output logic                    mcu_reset,
  output logic                    monitor_active,
  output logic                    fetch_restart,
  output logic [3:0]              pullup_port0,
  output logic [3:0]              pullup_port1,
  output logic [3:0]              ext_irq_ctrl,
  output pdw_pkg::pdw_init_t      init_ctrl,
  output logic                    sub_osc_run,
  output logic                    main_osc_run,
  output logic                    display_run,
  output logic                    timer3_run,
  output logic                    counter_io_pin_out,
  output logic                    counter_io_pin_oe,
  output logic                    port_hold
);
  // Two-flop synchronisers for all asynchronous inputs
  localparam int NSYNC = 12;
  // Pins and the interrupt input idle high through pull-ups; a zero reset value would
  // show a false edge on every pin right after reset
  localparam logic [NSYNC-1:0] SYNC_IDLE = 12'h1FF;
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;
  logic [NSYNC-1:0] sync_prev;
  wire  [NSYNC-1:0] async_in = {wdt_reset, drop_detect, timer3_underflow, int_pin_in,
                                port1_in, port0_in};

  genvar g;
  generate
    for (g = 0; g < NSYNC; g++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync_a[g]    <= SYNC_IDLE[g];
          sync_b[g]    <= SYNC_IDLE[g];
          sync_prev[g] <= SYNC_IDLE[g];
        end else begin
          sync_a[g]    <= async_in[g];
          sync_b[g]    <= sync_a[g];
          sync_prev[g] <= sync_b[g];
        end
      end
    end
  endgenerate

  wire [3:0] p0_s   = sync_b[3:0];
  wire [3:0] p1_s   = sync_b[7:4];
  wire [3:0] p0_pv  = sync_prev[3:0];
  wire [3:0] p1_pv  = sync_prev[7:4];
  wire       int_s  = sync_b[8];
  wire       int_pv = sync_prev[8];
  wire       t3_s   = sync_b[9];
  wire       t3_pv  = sync_prev[9];
  wire       drop_s = sync_b[10];
  wire       wdt_s  = sync_b[11];

  pdw_pkg::pdw_ctrl_t ctrl;
  pdw_pkg::pdw_state_t state;
  logic armed;
  logic keep_latch;
  logic warm_flag;
  logic t3f;
  logic wake_pend;

  // APB decode
  wire        wr_en     = psel & penable & pwrite;
  wire        sel_cmd   = (paddr == pdw_pkg::OFF_CMD);
  wire        sel_stat  = (paddr == pdw_pkg::OFF_STATUS);
  wire        sel_wen   = (paddr == pdw_pkg::OFF_WAKE_EN);
  wire        sel_wcnd  = (paddr == pdw_pkg::OFF_WAKE_CND);
  wire        sel_pwk   = (paddr == pdw_pkg::OFF_PIN_WAKE);
  wire        sel_pu0   = (paddr == pdw_pkg::OFF_PULLUP0);
  wire        sel_pu1   = (paddr == pdw_pkg::OFF_PULLUP1);
  wire        sel_exi   = (paddr == pdw_pkg::OFF_EXT_IRQ);
  wire        sel_core  = (paddr == pdw_pkg::OFF_CORE);
  wire        mapped    = sel_cmd | sel_stat | sel_wen | sel_wcnd | sel_pwk | sel_pu0 |
                          sel_pu1 | sel_exi | sel_core;
  wire        cmd_wr    = wr_en & sel_cmd & (state == pdw_pkg::PDW_RUN);
  wire [3:0]  cmd       = pwdata[3:0];
  // Any other instruction executed by the core is reported by a write to OFF_CORE
  wire        instr_done = cmd_wr | (wr_en & sel_core);

  wire do_keep   = cmd_wr & (cmd == pdw_pkg::CMD_MONITOR_KEEP);
  wire do_arm    = cmd_wr & (cmd == pdw_pkg::CMD_ARM);
  wire do_clk    = cmd_wr & (cmd == pdw_pkg::CMD_CLOCK_HOLD) & armed;
  wire do_ram    = cmd_wr & (cmd == pdw_pkg::CMD_RAM_HOLD) & armed;
  wire do_clrt3  = cmd_wr & (cmd == pdw_pkg::CMD_CLR_T3F);
  wire t3_event  = t3_s & ~t3_pv;

  // Key-on wakeup detection
  wire [3:0] p0_en   = {ctrl.wake_en[1], ctrl.wake_en[1], ctrl.wake_en[0], ctrl.wake_en[0]};
  wire [3:0] p1_en   = {ctrl.wake_en[3], ctrl.wake_en[3], ctrl.wake_en[2], ctrl.wake_en[2]};
  wire       p0_wake = |(p0_en & p0_pv & ~p0_s);
  wire [3:0] p1_lvl  = {{2{ctrl.wake_cond[2]}}, {2{ctrl.wake_cond[0]}}};
  wire [3:0] p1_byl  = {{2{ctrl.wake_cond[3]}}, {2{ctrl.wake_cond[1]}}};
  wire [3:0] p1_act  = p1_s ~^ p1_lvl;
  wire [3:0] p1_pact = p1_pv ~^ p1_lvl;
  wire       p1_wake = |(p1_en & p1_act & (p1_byl | ~p1_pact));
  wire       int_act  = ~(int_s ^ ctrl.ext_irq[pdw_pkg::EXI_LEVEL]);
  wire       int_pact = ~(int_pv ^ ctrl.ext_irq[pdw_pkg::EXI_LEVEL]);
  wire       int_wake = ctrl.pin_wake[pdw_pkg::PWK_ENABLE] &
                        ctrl.ext_irq[pdw_pkg::EXI_INPUT_EN] & int_act &
                        (~ctrl.pin_wake[pdw_pkg::PWK_EDGE] | ~int_pact);
  wire       ext_wake = p0_wake | p1_wake | int_wake;
  wire       sleeping = (state != pdw_pkg::PDW_RUN);
  wire       wake_now = (state == pdw_pkg::PDW_CLOCK_HOLD) ? (ext_wake | t3f)
                       : (state == pdw_pkg::PDW_RAM_HOLD) ? ext_wake : 1'b0;
  wire       cold     = drop_s | wdt_s;

  // Arm latch lives for exactly one following instruction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed <= 1'b0;
    end else if (instr_done) begin
      armed <= do_arm;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      keep_latch <= 1'b0;
    end else if (cold) begin
      keep_latch <= 1'b0;
    end else if (do_keep) begin
      keep_latch <= 1'b1;
    end
  end

  // Timer 3 flag: set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t3f <= 1'b0;
    end else if (t3_event && state != pdw_pkg::PDW_RAM_HOLD) begin
      t3f <= 1'b1;
    end else if (do_clrt3 || cold) begin
      t3f <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state     <= pdw_pkg::PDW_RUN;
      warm_flag <= 1'b0;
      wake_pend <= 1'b0;
    end else if (cold) begin
      state     <= pdw_pkg::PDW_RUN;
      warm_flag <= 1'b0;
      wake_pend <= 1'b1;
    end else begin
      wake_pend <= 1'b0;
      case (state)
        pdw_pkg::PDW_RUN: begin
          if (do_clk) begin
            state     <= pdw_pkg::PDW_CLOCK_HOLD;
          end else if (do_ram) begin
            state     <= pdw_pkg::PDW_RAM_HOLD;
          end
        end
        pdw_pkg::PDW_CLOCK_HOLD, pdw_pkg::PDW_RAM_HOLD: begin
          if (wake_now) begin
            state     <= pdw_pkg::PDW_RUN;
            warm_flag <= 1'b1;
            wake_pend <= 1'b1;
          end
        end
        default: state <= pdw_pkg::PDW_RUN;
      endcase
    end
  end

  // Retained control registers, written and read like accumulator transfers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= '{default: pdw_pkg::REG4_RESET};
    end else if (wr_en) begin
      if (sel_wen)  ctrl.wake_en   <= pwdata[3:0];
      if (sel_wcnd) ctrl.wake_cond <= pwdata[3:0];
      if (sel_pwk)  ctrl.pin_wake  <= pwdata[3:0];
      if (sel_pu0)  ctrl.pullup0   <= pwdata[3:0];
      if (sel_pu1)  ctrl.pullup1   <= pwdata[3:0];
      if (sel_exi)  ctrl.ext_irq   <= pwdata[3:0];
    end
  end

  wire [31:0] status_word = {26'h0, state == pdw_pkg::PDW_RAM_HOLD,
                             state == pdw_pkg::PDW_CLOCK_HOLD, armed, keep_latch,
                             t3f, warm_flag};
  wire [3:0]  reg_rd = sel_wen  ? ctrl.wake_en  : sel_wcnd ? ctrl.wake_cond :
                       sel_pwk  ? ctrl.pin_wake : sel_pu0  ? ctrl.pullup0   :
                       sel_pu1  ? ctrl.pullup1  : sel_exi  ? ctrl.ext_irq   : 4'h0;
  wire [31:0] rd_word = sel_stat ? status_word : {28'h0, reg_rd};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_word;
    end
  end

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // Outputs registered so the core sees clean strobes
  wire ram_hold = (state == pdw_pkg::PDW_RAM_HOLD);
  wire counter_io_pin_in  = (counter_pin_mode == pdw_pkg::COUNTER_IO_PIN_IN_MODE);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mcu_reset          <= 1'b0;
      monitor_active     <= 1'b1;
      fetch_restart      <= 1'b0;
      init_ctrl          <= '0;
      sub_osc_run        <= 1'b1;
      main_osc_run       <= 1'b1;
      display_run        <= 1'b1;
      timer3_run         <= 1'b1;
      counter_io_pin_out <= 1'b0;
      counter_io_pin_oe  <= 1'b0;
      port_hold          <= 1'b0;
      pullup_port0       <= 4'h0;
      pullup_port1       <= 4'h0;
      ext_irq_ctrl       <= 4'h0;
    end else begin
      mcu_reset          <= drop_s;
      monitor_active     <= ~sleeping | keep_latch;
      fetch_restart      <= wake_pend;
      init_ctrl.init_core      <= do_clk | do_ram;
      init_ctrl.init_sp        <= do_ram;
      init_ctrl.timers12_undef <= do_clk | do_ram;
      init_ctrl.display_off    <= do_ram;
      init_ctrl.osc_stop       <= do_ram;
      sub_osc_run        <= ~ram_hold;
      main_osc_run       <= ~sleeping;
      display_run        <= ~ram_hold;
      timer3_run         <= ~ram_hold;
      counter_io_pin_out <= 1'b0;
      counter_io_pin_oe  <= ram_hold & ~counter_io_pin_in;
      port_hold          <= sleeping;
      pullup_port0       <= ctrl.pullup0;
      pullup_port1       <= ctrl.pullup1;
      ext_irq_ctrl       <= ctrl.ext_irq;
    end
  end
endmodule : pdw_sequencer

// >>> dv/pdw_checker.sv
// Purpose: Port-level assertions for pdw_sequencer
// Assumes: One pclk domain, presetn async active low
// Notes:   Bound into every pdw_sequencer instance
`timescale 1ns/1ps
module pdw_checker (
  input wire logic                pclk,
  input wire logic                presetn,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [11:0]         paddr,
  input wire logic [31:0]         pwdata,
  input wire logic                pslverr,
  input wire logic                drop_detect,
  input wire logic [1:0]          counter_pin_mode,
  input wire logic                mcu_reset,
  input wire logic                monitor_active,
  input wire logic                fetch_restart,
  input wire logic [3:0]          pullup_port0,
  input wire pdw_pkg::pdw_init_t  init_ctrl,
  input wire logic                sub_osc_run,
  input wire logic                main_osc_run,
  input wire logic                display_run,
  input wire logic                timer3_run,
  input wire logic                counter_io_pin_out,
  input wire logic                counter_io_pin_oe,
  input wire logic                port_hold
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Two sync flops plus the output register
  property p_drop; drop_detect [*4] |=> mcu_reset; endproperty
  a_drop: assert property (p_drop) else $error("no reset on supply drop");
  property p_err; psel && penable && paddr > pdw_pkg::OFF_CORE |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("unmapped access not refused");
  property p_ok; psel && penable && paddr <= pdw_pkg::OFF_CORE && paddr[1:0] == 2'h0
    |-> !pslverr; endproperty
  a_ok: assert property (p_ok) else $error("mapped access refused");
  property p_pu; psel && penable && pwrite && paddr == pdw_pkg::OFF_PULLUP0
    |-> ##2 pullup_port0 == $past(pwdata[3:0], 2); endproperty
  a_pu: assert property (p_pu) else $error("pull-up output not updated");
  property p_hold; !main_osc_run |-> port_hold; endproperty
  a_hold: assert property (p_hold) else $error("ports not held in sleep");
  property p_ram; !sub_osc_run |-> !display_run && !timer3_run && !main_osc_run; endproperty
  a_ram: assert property (p_ram) else $error("clocks alive in RAM hold");
  property p_counter_io_pin; !sub_osc_run && $past(!sub_osc_run) && $stable(counter_pin_mode)
    |-> counter_io_pin_oe == (counter_pin_mode != pdw_pkg::COUNTER_IO_PIN_IN_MODE)
        && !counter_io_pin_out; endproperty
  a_counter_io_pin: assert property (p_counter_io_pin) else $error("counter pin wrong in RAM hold");
  // The init pulse comes one cycle before the hold outputs rise
  property p_init; $rose(port_hold)
    |-> $past(init_ctrl.init_core) && $past(init_ctrl.timers12_undef); endproperty
  a_init: assert property (p_init) else $error("core not initialised");
  property p_sp; init_ctrl.init_sp
    |-> init_ctrl.init_core && init_ctrl.osc_stop && init_ctrl.display_off; endproperty
  a_sp: assert property (p_sp) else $error("stack init outside RAM hold");
  property p_keep; port_hold && monitor_active |=> monitor_active || !port_hold; endproperty
  a_keep: assert property (p_keep) else $error("monitor dropped in sleep");
  property p_wake; $fell(port_hold) |-> ##[0:2] fetch_restart; endproperty
  a_wake: assert property (p_wake) else $error("no restart after wake");
endmodule : pdw_checker

bind pdw_sequencer pdw_checker chk_u (.*);

// >>> dv/pdw_wake_src.sv
// Purpose: Wakeup pins and timer 3 source facing the sequencer
// Assumes: Pins pulled up, so idle high
// Notes:   Pulses last 6 cycles so the 2-flop sync always sees them
`timescale 1ns/1ps
module pdw_wake_src (
  input  wire logic       pclk,
  input  wire logic       key_req,
  input  wire logic       uf_req,
  output logic      [3:0] port0_in,
  output logic      [3:0] port1_in,
  output logic            int_pin_in,
  output logic            timer3_underflow
);
  logic [2:0] key_cnt = 3'h0;
  logic [2:0] uf_cnt  = 3'h0;
  always_ff @(posedge pclk) begin
    key_cnt <= key_req ? 3'h6 : key_cnt - 3'(key_cnt != 3'h0);
    uf_cnt  <= uf_req ? 3'h6 : uf_cnt - 3'(uf_cnt != 3'h0);
  end
  assign port0_in         = {3'h7, key_cnt == 3'h0};
  assign port1_in         = 4'hF;
  assign int_pin_in       = 1'b1;
  assign timer3_underflow = uf_cnt != 3'h0;
endmodule : pdw_wake_src

// >>> dv/pdw_sequencer_tb.sv
// Purpose: Self-checking bench for pdw_sequencer
// Assumes: Zero-wait APB slave, 10 MHz pclk
// Notes:   Tests run in order and share register state
`timescale 1ns/1ps
module pdw_sequencer_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err_v;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_v;
  logic [3:0]  port0_in, port1_in, pullup_port0, pullup_port1, ext_irq_ctrl;
  logic [1:0]  counter_pin_mode;
  logic        int_pin_in, timer3_underflow, drop_detect, wdt_reset, key_req, uf_req;
  logic        mcu_reset, monitor_active, fetch_restart, sub_osc_run, main_osc_run;
  logic        display_run, timer3_run, counter_io_pin_out, counter_io_pin_oe, port_hold;
  pdw_pkg::pdw_init_t init_ctrl;
  int          err_count, checks, cyc, fr_cnt, sp_cnt, n0, s0;

  pdw_sequencer dut_u (.*);
  pdw_wake_src src_u (.pclk(pclk), .key_req(key_req), .uf_req(uf_req), .port0_in(port0_in),
    .port1_in(port1_in), .int_pin_in(int_pin_in), .timer3_underflow(timer3_underflow));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (fetch_restart === 1'b1) fr_cnt++;
    if (init_ctrl.init_sp === 1'b1) sp_cnt++;
    if (cyc == 20000) begin
      err_count++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic cmd(input logic [3:0] c);
    apb(1'b1, pdw_pkg::OFF_CMD, {28'h0, c});
  endtask : cmd
  task automatic st();
    apb(1'b0, pdw_pkg::OFF_STATUS, 32'h0);
  endtask : st
  task automatic src(input logic k);
    if (k) key_req <= 1'b1; else uf_req <= 1'b1;
    @(posedge pclk);
    key_req <= 1'b0;
    uf_req <= 1'b0;
  endtask : src
  // Bounded wait for the core clock to return
  task automatic wait_run();
    for (int n = 0; n < 40 && main_osc_run !== 1'b1; n++) @(posedge pclk);
  endtask : wait_run

  task automatic t_regs();
    logic [11:0] a;
    for (int i = 0; i < 6; i++) begin
      a = pdw_pkg::OFF_WAKE_EN + 12'(4 * i);
      apb(1'b0, a, 32'h0);
      chk(rd_v, 32'h0);
      apb(1'b1, a, 32'(i + 1));
      apb(1'b0, a, 32'h0);
      chk(rd_v, 32'(i + 1));
    end
    chk({pullup_port0, pullup_port1, ext_irq_ctrl}, 32'h456);
    apb(1'b0, 12'h024, 32'h0);
    chk(rd_v, 32'h0);
    chk(err_v, 1'b1);
    $display("test regs done");
  endtask : t_regs
  task automatic t_noarm();
    cmd(pdw_pkg::CMD_CLOCK_HOLD);
    repeat (3) @(posedge pclk);
    chk(main_osc_run, 1'b1);
    cmd(pdw_pkg::CMD_ARM);
    apb(1'b1, pdw_pkg::OFF_CORE, 32'h0);
    cmd(pdw_pkg::CMD_CLOCK_HOLD);
    repeat (3) @(posedge pclk);
    chk(main_osc_run, 1'b1);
    st();
    chk(rd_v & 32'h3F, 32'h0);
    $display("test noarm done");
  endtask : t_noarm
  task automatic t_ram();
    counter_pin_mode <= 2'h0;
    cmd(pdw_pkg::CMD_WDT_RESTART);
    s0 = sp_cnt;
    cmd(pdw_pkg::CMD_ARM);
    cmd(pdw_pkg::CMD_RAM_HOLD);
    repeat (3) @(posedge pclk);
    chk({main_osc_run, sub_osc_run, display_run, timer3_run, monitor_active, port_hold},
        32'h01);
    chk({counter_io_pin_oe, counter_io_pin_out}, 32'h2);
    chk(sp_cnt - s0, 32'h1);
    st();
    chk(rd_v & 32'h3F, 32'h20);
    counter_pin_mode <= pdw_pkg::COUNTER_IO_PIN_IN_MODE;
    repeat (3) @(posedge pclk);
    chk(counter_io_pin_oe, 1'b0);
    src(1'b0);
    repeat (15) @(posedge pclk);
    chk(port_hold, 1'b1);
    n0 = fr_cnt;
    src(1'b1);
    wait_run();
    chk(main_osc_run, 1'b1);
    repeat (3) @(posedge pclk);
    chk(fr_cnt - n0, 32'h1);
    apb(1'b1, pdw_pkg::OFF_CORE, 32'h0);
    st();
    chk(rd_v & 32'h3, 32'h1);
    apb(1'b0, pdw_pkg::OFF_PULLUP0, 32'h0);
    chk(rd_v, 32'h4);
    $display("test ram_hold done");
  endtask : t_ram
  task automatic t_clk();
    cmd(pdw_pkg::CMD_MONITOR_KEEP);
    cmd(pdw_pkg::CMD_MONITOR_KEEP);
    cmd(pdw_pkg::CMD_WDT_RESTART);
    s0 = sp_cnt;
    cmd(pdw_pkg::CMD_ARM);
    cmd(pdw_pkg::CMD_CLOCK_HOLD);
    repeat (3) @(posedge pclk);
    chk({main_osc_run, sub_osc_run, display_run, timer3_run, monitor_active, port_hold},
        32'h1F);
    chk(sp_cnt - s0, 32'h0);
    st();
    chk(rd_v & 32'h3F, 32'h15);
    n0 = fr_cnt;
    src(1'b0);
    wait_run();
    chk(main_osc_run, 1'b1);
    repeat (3) @(posedge pclk);
    chk(fr_cnt - n0, 32'h1);
    st();
    chk(rd_v & 32'h3F, 32'h7);
    n0 = fr_cnt;
    cmd(pdw_pkg::CMD_ARM);
    cmd(pdw_pkg::CMD_CLOCK_HOLD);
    repeat (8) @(posedge pclk);
    chk(main_osc_run, 1'b1);
    chk(fr_cnt - n0, 32'h1);
    cmd(pdw_pkg::CMD_CLR_T3F);
    st();
    chk(rd_v[pdw_pkg::ST_T3F], 1'b0);
    $display("test clock_hold done");
  endtask : t_clk
  task automatic t_cold();
    for (int i = 0; i < 2; i++) begin
      cmd(pdw_pkg::CMD_MONITOR_KEEP);
      if (i == 0) drop_detect <= 1'b1; else wdt_reset <= 1'b1;
      repeat (6) @(posedge pclk);
      if (i == 0) chk(mcu_reset, 1'b1);
      drop_detect <= 1'b0;
      wdt_reset <= 1'b0;
      repeat (6) @(posedge pclk);
      st();
      chk(rd_v & 32'h7, 32'h0);
    end
    $display("test cold done");
  endtask : t_cold
  // Level wake from RAM hold: port 1 high level first, then the interrupt pin high level
  task automatic t_lvl();
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, pdw_pkg::OFF_WAKE_EN, i ? 32'h0 : 32'h4);
      apb(1'b1, pdw_pkg::OFF_WAKE_CND, 32'h3);
      apb(1'b1, pdw_pkg::OFF_PIN_WAKE, 32'h1);
      apb(1'b1, pdw_pkg::OFF_EXT_IRQ, i ? 32'hC : 32'h4);
      n0 = fr_cnt;
      cmd(pdw_pkg::CMD_ARM);
      cmd(pdw_pkg::CMD_RAM_HOLD);
      repeat (8) @(posedge pclk);
      chk(fr_cnt - n0, 32'h1);
      st();
      chk(rd_v & 32'h3F, 32'h1);
    end
    $display("test level wake done");
  endtask : t_lvl

  task automatic report_and_stop();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0; drop_detect = 1'b0; wdt_reset = 1'b0; counter_pin_mode = 2'h0;
    key_req = 1'b0; uf_req = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_noarm();
    t_ram();
    t_clk();
    t_cold();
    t_lvl();
    report_and_stop();
  end
endmodule : pdw_sequencer_tb
